// File: core/output_terminal_function_select.sv
// Output terminal function select with APB register file
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module output_terminal_function_select
  import outsel_pkg::*;
#(
  parameter int SEQ_PULSE_LEN = SEQ_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_running,
  input wire logic zero_frequency,
  input wire logic fault_stop,
  input wire logic first_frequency_level_detect,
  input wire logic frequency_reached,
  input wire logic motor_overload_prealarm,
  input wire logic drive_overload_prewarn,
  input wire logic set_count_reached,
  input wire logic designated_count_reached,
  input wire logic length_reached,
  input wire logic step_sequence_cycle_done,
  input wire logic run_time_reached,
  output logic fast_multipurpose_output,
  output logic relay_one_contact,
  output logic irq
);
  // ------------------------------------------------------------
  // Status condition selection
  // ------------------------------------------------------------
  function automatic logic sel_cond(input logic [15:0] code, input logic seq_pulse);
    logic r;
    r = 1'b0;
    unique case (code)
      FC_NONE: r = 1'b0;
      FC_RUNNING: r = drive_running;
      FC_FAULT: r = fault_stop;
      FC_LEVEL1: r = first_frequency_level_detect;
      FC_FREQ_REACHED: r = frequency_reached;
      FC_ZERO_RUN: r = drive_running & zero_frequency;
      FC_MOTOR_OVL: r = motor_overload_prealarm;
      FC_DRIVE_OVL: r = drive_overload_prewarn;
      FC_SET_COUNT: r = set_count_reached;
      FC_DESIG_COUNT: r = designated_count_reached;
      FC_LENGTH: r = length_reached;
      FC_SEQ_DONE: r = seq_pulse;
      FC_RUN_TIME: r = run_time_reached;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_cond

  logic [15:0] fast_mode_q;
  logic [15:0] oc_func_q;
  logic [15:0] relay_func_q;
  logic [15:0] pulse_div_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic fast_out_q;
  logic relay_q;
  logic irq_q;
  logic seq_done_prev_q;
  logic [31:0] seq_cnt_q;
  logic [15:0] pulse_cnt_q;
  logic pulse_lvl_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access_wr = psel & penable & pwrite & pready_q;
  wire hit_mode = paddr == ADDR_FAST_MODE;
  wire hit_oc = paddr == ADDR_OC_FUNC;
  wire hit_relay = paddr == ADDR_RELAY_FUNC;
  wire hit_div = paddr == ADDR_PULSE_DIV;
  wire hit_ists = paddr == ADDR_IRQ_STATUS;
  wire hit_imask = paddr == ADDR_IRQ_MASK;
  wire hit_state = paddr == ADDR_OUT_STATE;
  wire mapped = hit_mode | hit_oc | hit_relay | hit_div | hit_ists | hit_imask | hit_state;
  wire [31:0] rd_mux = hit_mode ? {16'h0000, fast_mode_q} :
                       hit_oc ? {16'h0000, oc_func_q} :
                       hit_relay ? {16'h0000, relay_func_q} :
                       hit_div ? {16'h0000, pulse_div_q} :
                       hit_ists ? {30'h00000000, irq_status_q} :
                       hit_imask ? {30'h00000000, irq_mask_q} :
                       hit_state ? {30'h00000000, relay_q, fast_out_q} : 32'h00000000;

  // No wait state: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_mode_q <= FAST_MODE_RESET;
      oc_func_q <= OC_FUNC_RESET;
      relay_func_q <= RELAY_FUNC_RESET;
      pulse_div_q <= PULSE_DIV_RESET;
      irq_mask_q <= 2'h0;
    end else if (access_wr) begin
      if (hit_mode) fast_mode_q <= {15'h0000, pwdata[0]};
      if (hit_oc) oc_func_q <= pwdata[15:0];
      if (hit_relay) relay_func_q <= pwdata[15:0];
      // Clamp keeps software from pushing the rate over the limit
      if (hit_div) pulse_div_q <= (pwdata[15:0] < PULSE_DIV_RESET) ? PULSE_DIV_RESET
                                                                 : pwdata[15:0];
      if (hit_imask) irq_mask_q <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Sequence cycle pulse stretcher
  // ------------------------------------------------------------
  wire seq_rise = step_sequence_cycle_done & ~seq_done_prev_q;
  wire seq_pulse = seq_cnt_q != 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_done_prev_q <= 1'b0;
      seq_cnt_q <= 32'h00000000;
    end else begin
      seq_done_prev_q <= step_sequence_cycle_done;
      if (seq_rise) seq_cnt_q <= 32'(SEQ_PULSE_LEN);
      else if (seq_pulse) seq_cnt_q <= seq_cnt_q - 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // Pulse generator, half period of pulse_div_q cycles
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q <= 16'h0000;
      pulse_lvl_q <= 1'b0;
    end else if (pulse_cnt_q + 16'h0001 >= pulse_div_q) begin
      pulse_cnt_q <= 16'h0000;
      pulse_lvl_q <= ~pulse_lvl_q;
    end else begin
      pulse_cnt_q <= pulse_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Outputs and interrupts
  // ------------------------------------------------------------
  wire oc_cond = sel_cond(oc_func_q, seq_pulse);
  wire relay_cond = sel_cond(relay_func_q, seq_pulse);
  wire fast_d = (fast_mode_q[0] == FAST_MODE_PULSE) ? pulse_lvl_q : oc_cond;
  wire [1:0] rise = {relay_cond & ~relay_q, fast_d & ~fast_out_q};
  wire [1:0] clr = (access_wr & hit_ists) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_out_q <= 1'b0;
      relay_q <= 1'b0;
      irq_status_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      fast_out_q <= fast_d;
      relay_q <= relay_cond;
      irq_status_q <= (irq_status_q & ~clr) | rise;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fast_multipurpose_output = fast_out_q;
  assign relay_one_contact = relay_q;
  assign irq = irq_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_seq_start;
    step_sequence_cycle_done && !seq_done_prev_q;
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_write_access;
    psel && penable && pwrite && pready_q;
  endsequence

  property p_mode_pulse;
    @(posedge pclk) disable iff (!presetn)
      fast_mode_q[0] == FAST_MODE_PULSE |=> fast_out_q == $past(pulse_lvl_q);
  endproperty
  a_mode_pulse: assert property (p_mode_pulse) else $error("fast output not pulse");

  property p_mode_switch;
    @(posedge pclk) disable iff (!presetn)
      fast_mode_q[0] != FAST_MODE_PULSE |=> fast_out_q == $past(oc_cond);
  endproperty
  a_mode_switch: assert property (p_mode_switch) else $error("fast output not switch");

  property p_mode_bits;
    @(posedge pclk) disable iff (!presetn)
      fast_mode_q[15:1] == 15'h0000;
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode holds stray bits");

  property p_div_floor;
    @(posedge pclk) disable iff (!presetn)
      pulse_div_q >= PULSE_DIV_RESET;
  endproperty
  a_div_floor: assert property (p_div_floor) else $error("pulse rate too high");

  property p_pulse_hold;
    @(posedge pclk) disable iff (!presetn)
      pulse_cnt_q + 16'h0001 < pulse_div_q |=> $stable(pulse_lvl_q);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse toggled early");

  property p_pulse_wrap;
    @(posedge pclk) disable iff (!presetn)
      pulse_cnt_q + 16'h0001 >= pulse_div_q |=>
        pulse_cnt_q == 16'h0000 && pulse_lvl_q != $past(pulse_lvl_q);
  endproperty
  a_pulse_wrap: assert property (p_pulse_wrap) else $error("pulse did not toggle");

  property p_oc_write;
    @(posedge pclk) disable iff (!presetn)
      s_write_access ##0 hit_oc |=> oc_func_q == $past(pwdata[15:0]);
  endproperty
  a_oc_write: assert property (p_oc_write) else $error("open collector code not taken");

  property p_relay_write;
    @(posedge pclk) disable iff (!presetn)
      s_write_access ##0 hit_relay |=> relay_func_q == $past(pwdata[15:0]);
  endproperty
  a_relay_write: assert property (p_relay_write) else $error("relay code not taken");

  property p_none_off;
    @(posedge pclk) disable iff (!presetn)
      oc_func_q == FC_NONE && fast_mode_q[0] != FAST_MODE_PULSE |=> !fast_out_q;
  endproperty
  a_none_off: assert property (p_none_off) else $error("code 0 output active");

  property p_relay_none;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_NONE |=> !relay_q;
  endproperty
  a_relay_none: assert property (p_relay_none) else $error("code 0 relay active");

  property p_run;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_RUNNING |=> relay_q == $past(drive_running);
  endproperty
  a_run: assert property (p_run) else $error("running not followed");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_FAULT |=> relay_q == $past(fault_stop);
  endproperty
  a_fault: assert property (p_fault) else $error("fault not followed");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_LEVEL1 |=> relay_q == $past(first_frequency_level_detect);
  endproperty
  a_level: assert property (p_level) else $error("level detect not followed");

  property p_reached;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_FREQ_REACHED |=> relay_q == $past(frequency_reached);
  endproperty
  a_reached: assert property (p_reached) else $error("frequency reached not followed");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_ZERO_RUN && !drive_running |=> !relay_q;
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed on when stopped");

  property p_zero_run;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_ZERO_RUN |=> relay_q == $past(drive_running && zero_frequency);
  endproperty
  a_zero_run: assert property (p_zero_run) else $error("zero speed not followed");

  property p_motor;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_MOTOR_OVL |=> relay_q == $past(motor_overload_prealarm);
  endproperty
  a_motor: assert property (p_motor) else $error("motor prealarm not followed");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_DRIVE_OVL |=> relay_q == $past(drive_overload_prewarn);
  endproperty
  a_drive: assert property (p_drive) else $error("drive prewarn not followed");

  property p_set_count;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_SET_COUNT |=> relay_q == $past(set_count_reached);
  endproperty
  a_set_count: assert property (p_set_count) else $error("set count not followed");

  property p_desig_count;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_DESIG_COUNT |=> relay_q == $past(designated_count_reached);
  endproperty
  a_desig_count: assert property (p_desig_count) else $error("count not followed");

  property p_len;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_LENGTH |=> relay_q == $past(length_reached);
  endproperty
  a_len: assert property (p_len) else $error("length not followed");

  property p_seq;
    @(posedge pclk) disable iff (!presetn)
      s_seq_start |=> seq_cnt_q == 32'(SEQ_PULSE_LEN);
  endproperty
  a_seq: assert property (p_seq) else $error("sequence pulse not started");

  property p_seq_count;
    @(posedge pclk) disable iff (!presetn)
      seq_pulse && !seq_rise |=> seq_cnt_q == $past(seq_cnt_q) - 32'h00000001;
  endproperty
  a_seq_count: assert property (p_seq_count) else $error("sequence pulse miscounted");

  property p_seq_out;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_SEQ_DONE |=> relay_q == $past(seq_pulse);
  endproperty
  a_seq_out: assert property (p_seq_out) else $error("sequence pulse not followed");

  property p_run_time;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q == FC_RUN_TIME |=> relay_q == $past(run_time_reached);
  endproperty
  a_run_time: assert property (p_run_time) else $error("run time not followed");

  property p_relay_track;
    @(posedge pclk) disable iff (!presetn)
      relay_func_q != $past(relay_func_q) |=> relay_q == $past(relay_cond);
  endproperty
  a_relay_track: assert property (p_relay_track) else $error("code change not applied");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      |(irq_status_q & irq_mask_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      rise[1] |=> irq_status_q[1];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("relay rise not held");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      s_setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");

  property p_ready_once;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      s_setup ##0 !mapped |=> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");

endmodule : output_terminal_function_select
`default_nettype wire

// File: core/outsel_pkg.sv
// Constants for the output terminal function select block
package outsel_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_FAST_MODE = 12'h000;
  localparam logic [11:0] ADDR_OC_FUNC = 12'h004;
  localparam logic [11:0] ADDR_RELAY_FUNC = 12'h008;
  localparam logic [11:0] ADDR_PULSE_DIV = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  localparam logic [11:0] ADDR_OUT_STATE = 12'h018;
  localparam logic [15:0] FAST_MODE_RESET = 16'h0001;
  localparam logic [15:0] OC_FUNC_RESET = 16'h0000;
  localparam logic [15:0] RELAY_FUNC_RESET = 16'h0002;
  localparam logic FAST_MODE_PULSE = 1'b0;
  // ------------------------------------------------------------
  // Function codes
  // ------------------------------------------------------------
  localparam logic [15:0] FC_NONE = 16'h0000;
  localparam logic [15:0] FC_RUNNING = 16'h0001;
  localparam logic [15:0] FC_FAULT = 16'h0002;
  localparam logic [15:0] FC_LEVEL1 = 16'h0003;
  localparam logic [15:0] FC_FREQ_REACHED = 16'h0004;
  localparam logic [15:0] FC_ZERO_RUN = 16'h0005;
  localparam logic [15:0] FC_MOTOR_OVL = 16'h0006;
  localparam logic [15:0] FC_DRIVE_OVL = 16'h0007;
  localparam logic [15:0] FC_SET_COUNT = 16'h0008;
  localparam logic [15:0] FC_DESIG_COUNT = 16'h0009;
  localparam logic [15:0] FC_LENGTH = 16'h000A;
  localparam logic [15:0] FC_SEQ_DONE = 16'h000B;
  localparam logic [15:0] FC_RUN_TIME = 16'h000C;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SEQ_PULSE_MS = 250;
  localparam int SEQ_PULSE_CYCLES = CLK_HZ / 1000 * SEQ_PULSE_MS;
  localparam int PULSE_MAX_HZ = 100_000;
  // Half period at the top rate, rounded up so the rate never exceeds the limit
  localparam int PULSE_MIN_HALF = (CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
  localparam logic [15:0] PULSE_DIV_RESET = 16'(PULSE_MIN_HALF);
endpackage : outsel_pkg

// File: testbench/load_model.sv
// Load on the fast output terminal that measures the shortest half period
`timescale 1ns/1ns
`default_nettype none
module load_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic watch,
  input wire logic fast_multipurpose_output,
  output int min_half
);
  // ------------------------------------------------------------
  // Half period meter
  // ------------------------------------------------------------
  int run_q;
  logic prev_q;
  logic seen_q;
  // First edge after watch only starts the count, a partial half is never recorded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 0;
      prev_q <= 1'b0;
      seen_q <= 1'b0;
      min_half <= 1_000_000;
    end else begin
      prev_q <= fast_multipurpose_output;
      if (!watch) begin
        seen_q <= 1'b0;
        run_q <= 0;
      end else if (fast_multipurpose_output !== prev_q) begin
        if (seen_q && run_q < min_half) begin
          min_half <= run_q;
        end
        seen_q <= 1'b1;
        run_q <= 1;
      end else begin
        run_q <= run_q + 1;
      end
    end
  end
endmodule : load_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the output terminal function select block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import outsel_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SEQ_LEN = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, watch = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, fast, relay, irq;
  logic [12:0] cond = 0;
  logic [31:0] exp_q[$];
  int err_count = 0, n_tests = 0, min_half;
  output_terminal_function_select #(.SEQ_PULSE_LEN(SEQ_LEN)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_running(cond[1]), .fault_stop(cond[2]), .first_frequency_level_detect(cond[3]),
    .frequency_reached(cond[4]), .zero_frequency(cond[5]), .motor_overload_prealarm(cond[6]),
    .drive_overload_prewarn(cond[7]), .set_count_reached(cond[8]),
    .designated_count_reached(cond[9]), .length_reached(cond[10]),
    .step_sequence_cycle_done(cond[11]), .run_time_reached(cond[12]),
    .fast_multipurpose_output(fast), .relay_one_contact(relay), .irq(irq));
  load_model i_load (.pclk(pclk), .presetn(presetn), .watch(watch),
    .fast_multipurpose_output(fast), .min_half(min_half));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Expected terminal level for a code; bit c of cond is the condition behind code c, except code 5, which is bits 1 and 5 together
  function automatic logic out_for(input logic [15:0] c, input logic [12:0] v);
    if (c == FC_ZERO_RUN) return v[1] & v[5];
    if (c != FC_NONE && c <= FC_RUN_TIME) return v[c];
    return 1'b0;
  endfunction : out_for
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    if (!wr) exp_q.push_back(d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Read data monitor takes the oldest note whenever a read completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, exp_q.pop_front());
  end
  initial begin
    #(30000 * 50);
    err_count++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    int hi;
    void'($urandom(32'h6E52B967));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_FAST_MODE, 32'h1, 0);
    apb(0, ADDR_OC_FUNC, 32'h0, 0);
    apb(0, ADDR_RELAY_FUNC, 32'h2, 0);
    apb(0, 12'h020, 32'h0, 1);
    for (int c = 0; c < 14; c++) begin
      apb(1, ADDR_OC_FUNC, 32'(c), 0);
      apb(1, ADDR_RELAY_FUNC, 32'(c), 0);
      repeat (4) begin
        cond <= 13'($urandom) & ~13'h0801;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(32'(relay), 32'(out_for(16'(c), cond)));
        check(32'(fast), 32'(out_for(16'(c), cond)));
        @(posedge pclk);
      end
    end
    // Relay on the sequence code stays high for exactly the stretch length
    apb(1, ADDR_RELAY_FUNC, 32'(FC_SEQ_DONE), 0);
    cond <= 13'h0800;
    @(posedge pclk);
    cond <= 13'h0000;
    hi = 0;
    for (int k = 0; k < 2 * SEQ_LEN; k++) begin
      @(negedge pclk);
      if (relay === 1'b1) hi++;
    end
    check(32'(hi), 32'(SEQ_LEN));
    check(32'(SEQ_PULSE_CYCLES), 32'h004C4B40);
    @(posedge pclk);
    apb(1, ADDR_FAST_MODE, 32'h0, 0);
    apb(1, ADDR_PULSE_DIV, 32'h5, 0);
    apb(0, ADDR_PULSE_DIV, 32'(PULSE_DIV_RESET), 0);
    watch <= 1'b1;
    repeat (1000) @(posedge pclk);
    check(32'(min_half >= PULSE_MIN_HALF && min_half < 1000), 32'h1);
    watch <= 1'b0;
    apb(1, ADDR_FAST_MODE, 32'h1, 0);
    apb(1, ADDR_OC_FUNC, 32'h0, 0);
    apb(1, ADDR_RELAY_FUNC, 32'h2, 0);
    apb(1, ADDR_IRQ_MASK, 32'h0, 0);
    apb(1, ADDR_IRQ_STATUS, 32'h3, 0);
    cond <= 13'h0004;
    repeat (4) @(posedge pclk);
    apb(0, ADDR_IRQ_STATUS, 32'h2, 0);
    @(negedge pclk);
    check(32'(relay), 32'h1);
    check(32'(irq), 32'h0);
    @(posedge pclk);
    apb(1, ADDR_IRQ_MASK, 32'h2, 0);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    @(posedge pclk);
    apb(1, ADDR_IRQ_STATUS, 32'h2, 0);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check(32'(irq), 32'h0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
